// ### verilog/sasb_bank.sv
// Spectral alarm status bank: serial register slave, thresholds, band alarm evaluation.
// Assumes the FFT engine streams bins on mclk and pulses rec_done after each record,
// and the band-definition store presents limits for the selected sample rate.
`timescale 1ns/100ps
// Operation
// - Y-axis level-two threshold register, 16-bit unsigned.
// - Z-axis level-two threshold register, 16-bit unsigned.
// - System alarm threshold, 16 bits, format per target select bit.
// - Clear command (command bit 9) erases the level-one/level-two spectral alarm thresholds.
// - Save command (command bit 12) activates spectral alarm settings.
// - Save is ignored if a save was already taken since last clear.
// - Enabled indicators: pin one shows warnings, pin two shows critical alarms.
// - Record header carries band flags, worst peak and its bin.
// - Status bits 4..15 hold level-one/level-two flag pairs for bands 1..6.
// - Status bits 2..0 give most critical band; bit 3 reads zero.
// - Band flags use limits of the currently selected sample rate.
// - Per-axis peak register holds worst-case magnitude, 16 bits.
// - Per-axis bin register holds worst-case bin in low byte.
// - Flag sets only after condition persists over programmed record count.
// - Control bits enable axes, system alarm, polarity and target.
module sasb_bank
	import sasb_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic              spi_sclk,
	input  wire logic              spi_cs_b,
	input  wire logic              spi_din,
	output logic                   spi_dout,
	input  wire logic              bin_valid,
	input  wire logic [1:0]        bin_axis,
	input  wire logic [7:0]        bin_num,
	input  wire logic [15:0]       bin_mag,
	input  wire logic              rec_done,
	input  wire logic [5:0][7:0]   band_lo,
	input  wire logic [5:0][7:0]   band_hi,
	input  wire logic [15:0]       temp_word,
	input  wire logic [15:0]       supply_word,
	output logic                   aux_pin_one,
	output logic                   aux_pin_one_oe,
	output logic                   aux_pin_two,
	output logic                   aux_pin_two_oe,
	output logic                   cfg_clear,
	output logic                   cfg_save,
	output logic                   alarm_active,
	output logic                   sys_alarm,
	output logic                   hdr_valid,
	output logic [2:0][15:0]       hdr_stat,
	output logic [2:0][15:0]       hdr_peak,
	output logic [2:0][15:0]       hdr_bin
);
	// Byte write into a 16-bit register; odd address carries the high byte.
	function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
	                                         input logic [7:0] d);
		put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
	endfunction
	// -----------------------------------------------------------------
	// Serial slave
	// -----------------------------------------------------------------
	logic [2:0]  s1_ff, s2_ff;
	logic        sclk_d_ff;
	sasb_state_t st_ff, nxt_st;
	logic [15:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
	logic [4:0]  cnt_ff, nxt_cnt;
	logic        wr_ff, nxt_wr, dout_ff, nxt_dout;
	logic [6:0]  wadr_ff, nxt_wadr, radr_ff, nxt_radr;
	logic [7:0]  wdat_ff, nxt_wdat;
	logic [15:0] rdata;
	logic        sclk_s, cs_s, din_s;
	assign sclk_s = s2_ff[2];
	assign cs_s   = s2_ff[1];
	assign din_s  = s2_ff[0];
	always_comb begin
		nxt_st   = st_ff;
		nxt_rx   = rx_ff;
		nxt_tx   = tx_ff;
		nxt_cnt  = cnt_ff;
		nxt_wr   = 1'b0;
		nxt_wadr = wadr_ff;
		nxt_wdat = wdat_ff;
		nxt_radr = radr_ff;
		case (st_ff)
			SASB_IDLE: begin
				if (!cs_s) begin
					nxt_st  = SASB_SHIFT;
					nxt_tx  = rdata;
					nxt_cnt = 5'h00;
				end
			end
			SASB_SHIFT: begin
				if (cs_s) begin
					nxt_st = SASB_IDLE;
				end else if (sclk_s && !sclk_d_ff) begin
					nxt_rx  = {rx_ff[14:0], din_s};
					nxt_cnt = cnt_ff + 5'h01;
					if (cnt_ff == FRAME_LAST) begin
						nxt_cnt = 5'h00;
						nxt_tx  = rdata;
						if (nxt_rx[15]) begin
							nxt_wr   = 1'b1;
							nxt_wadr = nxt_rx[14:8];
							nxt_wdat = nxt_rx[7:0];
						end else begin
							nxt_radr = nxt_rx[14:8];
						end
					end
				end else if (!sclk_s && sclk_d_ff && cnt_ff != 5'h00) begin
					nxt_tx = {tx_ff[14:0], 1'b0};
				end
			end
			default: nxt_st = SASB_IDLE;
		endcase
		nxt_dout = tx_ff[15];
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff     <= 3'h6;
			s2_ff     <= 3'h6;
			sclk_d_ff <= 1'b1;
			st_ff     <= SASB_IDLE;
			rx_ff     <= ZERO16;
			tx_ff     <= ZERO16;
			cnt_ff    <= 5'h00;
			wr_ff     <= 1'b0;
			wadr_ff   <= 7'h00;
			wdat_ff   <= 8'h00;
			radr_ff   <= 7'h00;
			dout_ff   <= 1'b0;
		end else begin
			s1_ff     <= {spi_sclk, spi_cs_b, spi_din};
			s2_ff     <= s1_ff;
			sclk_d_ff <= sclk_s;
			st_ff     <= nxt_st;
			rx_ff     <= nxt_rx;
			tx_ff     <= nxt_tx;
			cnt_ff    <= nxt_cnt;
			wr_ff     <= nxt_wr;
			wadr_ff   <= nxt_wadr;
			wdat_ff   <= nxt_wdat;
			radr_ff   <= nxt_radr;
			dout_ff   <= nxt_dout;
		end
	end
	assign spi_dout = dout_ff;
	// -----------------------------------------------------------------
	// Configuration registers and commands
	// -----------------------------------------------------------------
	logic [1:0][2:0][15:0] thr_ff, nxt_thr;
	logic [15:0] smag_ff, nxt_smag, ctl_ff, nxt_ctl, aux_ff, nxt_aux;
	logic        used_ff, nxt_used, act_ff, nxt_act, clr_ff, nxt_clr, sav_ff, nxt_sav;
	logic [2:0][15:0] stat_ff, peak_ff, wbin_ff;
	logic        sys_ff;
	logic        hib, do_clr, do_sav;
	logic [6:0]  wa;
	always_comb begin
		wa       = {wadr_ff[6:1], 1'b0};
		hib      = wadr_ff[0];
		nxt_thr  = thr_ff;
		nxt_smag = smag_ff;
		nxt_ctl  = ctl_ff;
		nxt_aux  = aux_ff;
		do_clr   = 1'b0;
		do_sav   = 1'b0;
		if (wr_ff) begin
			for (int a = 0; a < NAX; a++) begin
				if (wa == ADR_X_MAG1 + 7'(2 * a))
					nxt_thr[0][a] = put_byte(thr_ff[0][a], hib, wdat_ff);
				if (wa == ADR_X_MAG2 + 7'(2 * a))
					nxt_thr[1][a] = put_byte(thr_ff[1][a], hib, wdat_ff);
			end
			if (wa == ADR_S_MAG)
				nxt_smag = put_byte(smag_ff, hib, wdat_ff);
			if (wa == ADR_CTRL)
				nxt_ctl = put_byte(ctl_ff, hib, wdat_ff);
			if (wa == ADR_AUX_CFG)
				nxt_aux = put_byte(aux_ff, hib, wdat_ff);
			if (wa == ADR_GLOBAL_COMMAND_WORD) begin
				do_clr = hib && wdat_ff[CMD_CLR_BIT - $bits(wdat_ff)];
				do_sav = hib && wdat_ff[CMD_SAVE_BIT - $bits(wdat_ff)];
			end
		end
		if (do_clr)
			nxt_thr = '0;
		nxt_sav  = do_sav && (!used_ff || do_clr);
		nxt_used = nxt_sav || (used_ff && !do_clr);
		nxt_act  = nxt_sav || (act_ff && !do_clr);
		nxt_clr  = do_clr;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			thr_ff  <= '0;
			smag_ff <= ZERO16;
			ctl_ff  <= CTL_RST;
			aux_ff  <= ZERO16;
			used_ff <= 1'b0;
			act_ff  <= 1'b0;
			clr_ff  <= 1'b0;
			sav_ff  <= 1'b0;
		end else begin
			thr_ff  <= nxt_thr;
			smag_ff <= nxt_smag;
			ctl_ff  <= nxt_ctl;
			aux_ff  <= nxt_aux;
			used_ff <= nxt_used;
			act_ff  <= nxt_act;
			clr_ff  <= nxt_clr;
			sav_ff  <= nxt_sav;
		end
	end
	// Read mux; the command word and unmapped addresses read as zero.
	always_comb begin
		rdata = ZERO16;
		for (int a = 0; a < NAX; a++) begin
			if ({radr_ff[6:1], 1'b0} == ADR_X_MAG1 + 7'(2 * a)) rdata = thr_ff[0][a];
			if ({radr_ff[6:1], 1'b0} == ADR_X_MAG2 + 7'(2 * a)) rdata = thr_ff[1][a];
			if ({radr_ff[6:1], 1'b0} == ADR_X_STAT + 7'(2 * a)) rdata = stat_ff[a];
			if ({radr_ff[6:1], 1'b0} == ADR_X_PEAK + 7'(2 * a)) rdata = peak_ff[a];
			if ({radr_ff[6:1], 1'b0} == ADR_X_FREQ + 7'(2 * a)) rdata = wbin_ff[a];
		end
		if ({radr_ff[6:1], 1'b0} == ADR_S_MAG)   rdata = smag_ff;
		if ({radr_ff[6:1], 1'b0} == ADR_CTRL)    rdata = ctl_ff;
		if ({radr_ff[6:1], 1'b0} == ADR_AUX_CFG) rdata = aux_ff;
	end
	// -----------------------------------------------------------------
	// Band alarm evaluation
	// -----------------------------------------------------------------
	logic [2:0][5:0][1:0]      hit_ff, nxt_hit;
	logic [2:0][5:0][1:0][4:0] per_ff, nxt_per;
	logic [2:0][15:0] wpk_ff, nxt_wpk, nxt_stat, nxt_peak, nxt_wbin;
	logic [2:0][7:0]  wnum_ff, nxt_wnum;
	logic [2:0][2:0]  wband_ff, nxt_wband;
	logic             nxt_sys, nxt_hv, hv_ff, p1_ff, p2_ff, o1_ff, o2_ff;
	logic             inb, anyf;
	logic [4:0]       c;
	logic [15:0]      sref;
	always_comb begin
		nxt_hit   = hit_ff;
		nxt_per   = per_ff;
		nxt_wpk   = wpk_ff;
		nxt_wnum  = wnum_ff;
		nxt_wband = wband_ff;
		nxt_stat  = stat_ff;
		nxt_peak  = peak_ff;
		nxt_wbin  = wbin_ff;
		nxt_sys   = sys_ff;
		nxt_hv    = 1'b0;
		inb       = 1'b0;
		anyf      = 1'b0;
		c         = 5'h00;
		sref      = ctl_ff[CTL_TGT] ? temp_word : supply_word;
		if (bin_valid && bin_axis < 2'(NAX)) begin
			for (int b = 0; b < NBAND; b++) begin
				inb = bin_num >= band_lo[b] && bin_num <= band_hi[b];
				for (int l = 0; l < 2; l++)
					if (inb && bin_mag > thr_ff[l][bin_axis])
						nxt_hit[bin_axis][b][l] = 1'b1;
				if (inb && bin_mag > thr_ff[0][bin_axis] && bin_mag > nxt_wpk[bin_axis]) begin
					nxt_wpk[bin_axis]   = bin_mag;
					nxt_wnum[bin_axis]  = bin_num;
					nxt_wband[bin_axis] = 3'(b + 1);
				end
			end
		end
		if (rec_done) begin
			nxt_hv = 1'b1;
			for (int a = 0; a < NAX; a++) begin
				nxt_stat[a] = ZERO16;
				for (int b = 0; b < NBAND; b++) begin
					for (int l = 0; l < 2; l++) begin
						c = 5'h00;
						if (act_ff && ctl_ff[a] && hit_ff[a][b][l])
							c = (per_ff[a][b][l] < PERS_SAT) ? per_ff[a][b][l] + 5'h01
							                                 : PERS_SAT;
						nxt_per[a][b][l] = c;
						nxt_stat[a][STAT_LSB + 2 * b + l] = c > {1'b0, ctl_ff[CTL_DLY_LSB +: 4]};
					end
				end
				anyf = |nxt_stat[a];
				nxt_stat[a][2:0] = anyf ? wband_ff[a] : 3'h0;
				nxt_peak[a] = anyf ? wpk_ff[a] : ZERO16;
				nxt_wbin[a] = anyf ? {8'h00, wnum_ff[a]} : ZERO16;
			end
			nxt_sys = ctl_ff[CTL_EN_S] &&
			          (ctl_ff[CTL_POL] ? sref < smag_ff : sref > smag_ff);
			nxt_hit   = '0;
			nxt_wpk   = '0;
			nxt_wnum  = '0;
			nxt_wband = '0;
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hit_ff   <= '0;
			per_ff   <= '0;
			wpk_ff   <= '0;
			wnum_ff  <= '0;
			wband_ff <= '0;
			stat_ff  <= '0;
			peak_ff  <= '0;
			wbin_ff  <= '0;
			sys_ff   <= 1'b0;
			hv_ff    <= 1'b0;
		end else begin
			hit_ff   <= nxt_hit;
			per_ff   <= nxt_per;
			wpk_ff   <= nxt_wpk;
			wnum_ff  <= nxt_wnum;
			wband_ff <= nxt_wband;
			stat_ff  <= nxt_stat;
			peak_ff  <= nxt_peak;
			wbin_ff  <= nxt_wbin;
			sys_ff   <= nxt_sys;
			hv_ff    <= nxt_hv;
		end
	end
	// -----------------------------------------------------------------
	// Indicator pins
	// -----------------------------------------------------------------
	// Pins follow the status registers one cycle later, and also change on control or aux-config writes.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			p1_ff <= 1'b0;
			p2_ff <= 1'b0;
			o1_ff <= 1'b0;
			o2_ff <= 1'b0;
		end else begin
			o1_ff <= ctl_ff[CTL_IND] && aux_ff[AUX_ONE_SEL];
			o2_ff <= ctl_ff[CTL_IND] && aux_ff[AUX_TWO_SEL];
			p1_ff <= ctl_ff[CTL_IND] && aux_ff[AUX_ONE_SEL] && |(stat_ff & {NAX{L1_MASK}});
			p2_ff <= ctl_ff[CTL_IND] && aux_ff[AUX_TWO_SEL] && |(stat_ff & {NAX{L2_MASK}});
		end
	end
	assign aux_pin_one    = p1_ff;
	assign aux_pin_one_oe = o1_ff;
	assign aux_pin_two    = p2_ff;
	assign aux_pin_two_oe = o2_ff;
	assign cfg_clear      = clr_ff;
	assign cfg_save       = sav_ff;
	assign alarm_active   = act_ff;
	assign sys_alarm      = sys_ff;
	assign hdr_valid      = hv_ff;
	assign hdr_stat       = stat_ff;
	assign hdr_peak       = peak_ff;
	assign hdr_bin        = wbin_ff;
endmodule // sasb_bank

// ### verilog/sasb_pkg.sv
// Constants for the spectral alarm status bank.
// Assumes 16-bit serial frames: bit 15 write flag, bits 14:8 byte address, bits 7:0 data.
package sasb_pkg;
	localparam int NAX   = 3;
	localparam int NBAND = 6;
	localparam int FRAME = 16;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	// Byte addresses of the registers; even address is the low byte.
	localparam logic [6:0] ADR_AUX_CFG  = 7'h36;
	localparam logic [6:0] ADR_GLOBAL_COMMAND_WORD = 7'h3E;
	localparam logic [6:0] ADR_X_MAG1   = 7'h50;
	localparam logic [6:0] ADR_Y_MAG1   = 7'h52;
	localparam logic [6:0] ADR_Z_MAG1   = 7'h54;
	localparam logic [6:0] ADR_X_MAG2   = 7'h56;
	localparam logic [6:0] ADR_Y_MAG2   = 7'h58;
	localparam logic [6:0] ADR_Z_MAG2   = 7'h5A;
	localparam logic [6:0] ADR_S_MAG    = 7'h5C;
	localparam logic [6:0] ADR_CTRL     = 7'h5E;
	localparam logic [6:0] ADR_X_STAT   = 7'h60;
	localparam logic [6:0] ADR_X_PEAK   = 7'h66;
	localparam logic [6:0] ADR_X_FREQ   = 7'h70;
	localparam logic [6:0] ADR_Z_FREQ   = 7'h74;
	// Command and control bit positions.
	localparam int CMD_CLR_BIT  = 9;
	localparam int CMD_SAVE_BIT = 12;
	localparam int CTL_EN_S     = 3;
	localparam int CTL_TGT      = 4;
	localparam int CTL_POL      = 5;
	localparam int CTL_IND      = 6;
	localparam int CTL_DLY_LSB  = 8;
	localparam int AUX_ONE_SEL  = 2;
	localparam int AUX_TWO_SEL  = 3;
	localparam int STAT_LSB     = 4;
	localparam logic [15:0] CTL_RST  = 16'h0080;
	localparam logic [15:0] ZERO16   = 16'h0000;
	localparam logic [15:0] L1_MASK  = 16'h5550;
	localparam logic [15:0] L2_MASK  = 16'hAAA0;
	localparam logic [4:0]  PERS_SAT = 5'h10;
	typedef enum logic [1:0] {
		SASB_IDLE  = 2'b01,
		SASB_SHIFT = 2'b10
	} sasb_state_t;
endpackage

// ### test/sasb_bank_monitor.sv
// Assertion checker for the spectral alarm status bank, bound to its top module.
// Assumes one clock, mclk, and the active-low asynchronous reset rst_b.
`timescale 1ns/100ps
module sasb_bank_monitor
	import sasb_pkg::*;
(
	input wire logic             mclk,
	input wire logic             rst_b,
	input wire logic             rec_done,
	input wire logic             cfg_clear,
	input wire logic             cfg_save,
	input wire logic             alarm_active,
	input wire logic             sys_alarm,
	input wire logic             hdr_valid,
	input wire logic [2:0][15:0] hdr_stat,
	input wire logic [2:0][15:0] hdr_peak,
	input wire logic [2:0][15:0] hdr_bin,
	input wire logic             aux_pin_one,
	input wire logic             aux_pin_two
);
	logic        saved_ff;
	logic        nxt_saved;
	logic [15:0] all_flags;

	// A save counts until the next clear; a clear and save together leave it saved.
	always_comb begin
		nxt_saved = saved_ff;
		if (cfg_clear) nxt_saved = 1'b0;
		if (cfg_save) nxt_saved = 1'b1;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) saved_ff <= 1'b0;
		else saved_ff <= nxt_saved;
	end
	assign all_flags = hdr_stat[0] | hdr_stat[1] | hdr_stat[2];

	// ------
	// Assertions
	// ------
	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	property p_clr_off; cfg_clear && !cfg_save |=> !alarm_active; endproperty
	a_clr_off: assert property (p_clr_off) else $error("active after clear");
	property p_save_on; cfg_save |=> alarm_active; endproperty
	a_save_on: assert property (p_save_on) else $error("save did not activate");
	property p_save_once; cfg_save && !cfg_clear |-> !saved_ff; endproperty
	a_save_once: assert property (p_save_once) else $error("second save taken");
	property p_hdr_time; rec_done |=> hdr_valid; endproperty
	a_hdr_time: assert property (p_hdr_time) else $error("header late");
	property p_hdr_hold; !hdr_valid |-> $stable(hdr_stat) && $stable(hdr_peak); endproperty
	a_hdr_hold: assert property (p_hdr_hold) else $error("status moved");
	property p_fmt; hdr_valid |-> (hdr_stat[0][3] | hdr_stat[1][3] | hdr_stat[2][3]) == 1'b0;
	endproperty
	a_fmt: assert property (p_fmt) else $error("unused status bit set");
	property p_band; hdr_valid && hdr_stat[0][15:4] != 12'h000
		|-> hdr_stat[0][2:0] inside {[3'h1:3'h6]}; endproperty
	a_band: assert property (p_band) else $error("band field out of range");
	property p_peak_zero; hdr_valid && hdr_stat[0][15:4] == 12'h000
		|-> hdr_peak[0] == ZERO16 && hdr_bin[0] == ZERO16; endproperty
	a_peak_zero: assert property (p_peak_zero) else $error("peak without flag");
	property p_bin_hi; hdr_valid |-> {hdr_bin[0][15:8], hdr_bin[1][15:8]} == 16'h0000;
	endproperty
	a_bin_hi: assert property (p_bin_hi) else $error("bin upper byte set");
	property p_quiet; hdr_valid && !$past(alarm_active) |-> hdr_stat == 48'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("flags while inactive");
	property p_sys_hold; !$past(rec_done) |-> $stable(sys_alarm); endproperty
	a_sys_hold: assert property (p_sys_hold) else $error("system alarm moved");
	property p_pin_one; aux_pin_one |-> ($past(all_flags) & L1_MASK) != ZERO16; endproperty
	a_pin_one: assert property (p_pin_one) else $error("warning pin without flag");
	property p_pin_two; aux_pin_two |-> ($past(all_flags) & L2_MASK) != ZERO16; endproperty
	a_pin_two: assert property (p_pin_two) else $error("critical pin without flag");
endmodule // sasb_bank_monitor

bind sasb_bank sasb_bank_monitor sasb_bank_monitor_i (
	.mclk, .rst_b, .rec_done, .cfg_clear, .cfg_save, .alarm_active, .sys_alarm,
	.hdr_valid, .hdr_stat, .hdr_peak, .hdr_bin, .aux_pin_one, .aux_pin_two
);

// ### test/sasb_host.sv
// Host processor model: serial master in clock mode 3, one 16-bit frame per call.
// Assumes the bank samples on rising sclk and shifts out after falling sclk.
`timescale 1ns/100ps
module sasb_host
	import sasb_pkg::*;
(
	input  wire logic mclk,
	input  wire logic spi_dout,
	output logic      spi_sclk,
	output logic      spi_cs_b,
	output logic      spi_din
);
	initial begin
		spi_sclk = 1'b1;
		spi_cs_b = 1'b1;
		spi_din = 1'b0;
	end
	// Five mclk per half period leaves margin over the two-flop synchroniser.
	task automatic half;
		repeat (5) @(posedge mclk);
		#1;
	endtask
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		spi_cs_b = 1'b0;
		half;
		for (int i = FRAME - 1; i >= 0; i--) begin
			spi_sclk = 1'b0;
			spi_din = w[i];
			half;
			spi_sclk = 1'b1;
			r[i] = spi_dout;
			half;
		end
		spi_cs_b = 1'b1;
		// A released data line shows the inverse, so a stale bit is never taken.
		spi_din = ~spi_din;
		half;
	endtask
endmodule // sasb_host

// ### test/tb_spectral_alarm_status_bank.sv
// Testbench for the spectral alarm status bank.
// Drives registers through the host model and feeds records of spectral bins.
`timescale 1ns/100ps
module tb_spectral_alarm_status_bank
	import sasb_pkg::*;
;
	logic             mclk, rst_b, bin_valid, rec_done, spi_sclk, spi_cs_b, spi_din, spi_dout;
	logic             aux_pin_one, aux_pin_one_oe, aux_pin_two, aux_pin_two_oe;
	logic             cfg_clear, cfg_save, alarm_active, sys_alarm, hdr_valid;
	logic [1:0]       bin_axis;
	logic [7:0]       bin_num;
	logic [15:0]      bin_mag, temp_word, supply_word, rd;
	logic [5:0][7:0]  band_lo, band_hi;
	logic [2:0][15:0] hdr_stat, hdr_peak, hdr_bin;
	int               failures, n_compared, n_clr, n_save, cycles;

	sasb_bank sasb_bank_i (.mclk, .rst_b, .spi_sclk, .spi_cs_b, .spi_din, .spi_dout,
		.bin_valid, .bin_axis, .bin_num, .bin_mag, .rec_done, .band_lo, .band_hi,
		.temp_word, .supply_word, .aux_pin_one, .aux_pin_one_oe, .aux_pin_two,
		.aux_pin_two_oe, .cfg_clear, .cfg_save, .alarm_active, .sys_alarm,
		.hdr_valid, .hdr_stat, .hdr_peak, .hdr_bin);
	sasb_host sasb_host_i (.mclk, .spi_dout, .spi_sclk, .spi_cs_b, .spi_din);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cfg_clear === 1'b1) n_clr++;
		if (cfg_save === 1'b1) n_save++;
		if (cycles == 40000) begin
			failures++;
			finish_test;
		end
	end

	// ------
	// Tasks
	// ------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		sasb_host_i.xfer({1'b1, a, d}, rd);
	endtask
	task automatic wr16(input logic [6:0] a, input logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 7'h01, d[15:8]);
	endtask
	// Read data follows one frame behind its address.
	task automatic rd16(input logic [6:0] a);
		sasb_host_i.xfer({1'b0, a, 8'h00}, rd);
		sasb_host_i.xfer({1'b0, a, 8'h00}, rd);
	endtask
	task automatic put_bin(input logic [1:0] a, input logic [7:0] n, input logic [15:0] m);
		@(posedge mclk);
		#1;
		bin_valid = 1'b1;
		bin_axis = a;
		bin_num = n;
		bin_mag = m;
	endtask
	// Bin 0x19 lies outside every band, so its large magnitude must not count.
	task automatic record;
		put_bin(2'h0, 8'h0F, 16'h0150);
		put_bin(2'h0, 8'h19, 16'hF000);
		put_bin(2'h1, 8'h23, 16'h0300);
		put_bin(2'h2, 8'h0F, 16'hFFFF);
		@(posedge mclk);
		#1;
		bin_valid = 1'b0;
		rec_done = 1'b1;
		@(posedge mclk);
		#1;
		rec_done = 1'b0;
	endtask
	task automatic finish_test;
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------
	// Sequence
	// ------
	initial begin
		rst_b = 1'b0;
		bin_valid = 1'b0;
		rec_done = 1'b0;
		bin_axis = 2'h0;
		bin_num = 8'h00;
		bin_mag = 16'h0000;
		temp_word = 16'h2000;
		supply_word = 16'h0000;
		band_lo = 48'hC8B4A0781E0A;
		band_hi = 48'hD2BEAA822814;
		repeat (5) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		for (int a = 8'h56; a <= 8'h74; a += 2) begin
			rd16(7'(a));
			chk(rd, (a == 8'h5E) ? CTL_RST : ZERO16);
		end
		rd16(ADR_GLOBAL_COMMAND_WORD);
		chk(rd, ZERO16);
		wr16(ADR_Y_MAG2, 16'h1234);
		wr16(ADR_Z_MAG2, 16'h5678);
		wr16(ADR_S_MAG, 16'h1000);
		wr16(ADR_X_STAT, 16'hFFFF);
		rd16(ADR_Y_MAG2);
		chk(rd, 16'h1234);
		rd16(ADR_Z_MAG2);
		chk(rd, 16'h5678);
		rd16(ADR_S_MAG);
		chk(rd, 16'h1000);
		rd16(ADR_X_STAT);
		chk(rd, ZERO16);
		wr(ADR_GLOBAL_COMMAND_WORD + 7'h01, 8'h02);
		chk(16'(n_clr), 16'h0001);
		rd16(ADR_Z_MAG2);
		chk(rd, ZERO16);
		wr16(ADR_X_MAG1, 16'h0100);
		wr16(ADR_X_MAG2, 16'h0200);
		wr16(ADR_Y_MAG1, 16'h0100);
		wr16(ADR_Y_MAG2, 16'h0200);
		wr(ADR_AUX_CFG, 8'h0C);
		wr16(ADR_CTRL, 16'h01DB);
		wr(ADR_GLOBAL_COMMAND_WORD + 7'h01, 8'h10);
		chk({15'h0000, alarm_active}, 16'h0001);
		wr(ADR_GLOBAL_COMMAND_WORD + 7'h01, 8'h10);
		chk(16'(n_save), 16'h0001);
		record;
		chk(hdr_stat[0], ZERO16);
		record;
		chk({15'h0000, hdr_valid}, 16'h0001);
		chk(hdr_stat[0], 16'h0011);
		chk(hdr_stat[1], 16'h00C2);
		chk(hdr_stat[2], ZERO16);
		chk(hdr_peak[1], 16'h0300);
		chk(hdr_bin[0], 16'h000F);
		chk(hdr_peak[0], 16'h0150);
		chk({15'h0000, sys_alarm}, 16'h0001);
		@(posedge mclk);
		#1;
		chk({12'h000, aux_pin_one, aux_pin_one_oe, aux_pin_two, aux_pin_two_oe}, 16'h000F);
		rd16(ADR_X_STAT);
		chk(rd, 16'h0011);
		rd16(ADR_X_PEAK + 7'h02);
		chk(rd, 16'h0300);
		rd16(ADR_X_FREQ + 7'h02);
		chk(rd, 16'h0023);
		band_lo[0] = 8'h50;
		band_hi[0] = 8'h60;
		record;
		chk(hdr_stat[0], ZERO16);
		// below-threshold polarity, then supply as source
		wr(ADR_CTRL, 8'hFB);
		record;
		chk({15'h0000, sys_alarm}, 16'h0000);
		wr(ADR_CTRL, 8'hEB);
		record;
		chk({15'h0000, sys_alarm}, 16'h0001);
		wr(ADR_GLOBAL_COMMAND_WORD + 7'h01, 8'h02);
		record;
		chk(hdr_stat[1], ZERO16);
		finish_test;
	end
endmodule // tb_spectral_alarm_status_bank
